/* File: hdl/pmd_defs.svh */
`ifndef PMD_DEFS_SVH
`define PMD_DEFS_SVH
// Notes on behaviour
// [R1] Host loads setup registers, then an operations write starts the run.
// [R2] On finish the engine signals completion and returns to idle.
// [R3] Completion sets a sticky status bit, gated by enable onto interrupt.
// [R4] Pixels of 1, 2, 4 or 8 bits packed in 32-bit words.
// [R5] Each map picks a packing order; orders are converted automatically.
// [R6] Source combines with destination per pixel; result written back.
// [R7] Pattern pixel chooses between two programmed combining functions.
// [R8] A mask pixel may block update of its destination pixel.
// [R9] Optional pattern from source: zero source pixels give pattern zero.
// [R10] Destination update may depend on comparing destination to a value.
// [R11] Pointers advance after each pixel until the programmed limit.
// [R12] Source and pattern pointers wrap to the opposite edge of the map.
// [R13] Writes outside the destination map are suppressed; stepping goes on.
// [R14] Mask addressed by destination coordinates minus mask origin offsets.
// [R15] Fixed source or pattern uses foreground and background colours.
// [R16] Variable data only ever comes from memory fetched by the engine.
// [R17] A 4MB window above the video base is video, the rest system memory.
// [R18] Maps have base, width-1, height-1 and format registers.
// [R19] Maps up to 4096 square; operations register picks the maps.
// [R20] Host keeps source and destination depth equal, pattern one bit.
// [R21] The mask map is always one bit per pixel.
// [R22] Host can suspend or terminate a running operation.
// [R23] Mask enabled: mask 0 blocks update, mask 1 allows it.
// [R24] Destination coordinates are signed 16 bit; outside band never wraps.
// [R25] A readable busy bit runs from start until completion or termination.
`define PMD_OFF_OPS 8'h00
`define PMD_OFF_STATUS 8'h04
`define PMD_OFF_CTRL 8'h08
`define PMD_OFF_IRQEN 8'h0c
`define PMD_OFF_IRQST 8'h10
`define PMD_OFF_FG 8'h14
`define PMD_OFF_BG 8'h18
`define PMD_OFF_CMP 8'h1c
`define PMD_OFF_VBASE 8'h20
`define PMD_OFF_DIM 8'h24
`define PMD_OFF_SRCXY 8'h28
`define PMD_OFF_PATXY 8'h2c
`define PMD_OFF_DSTXY 8'h30
`define PMD_OFF_MOFF 8'h34
`define PMD_MAP_REGION 2'h1
`define PMD_MAP_BASE 2'h0
`define PMD_MAP_SIZE 2'h1
`define PMD_MAP_FMT 2'h2
`define PMD_MASK_MAP 2'h3
`define PMD_OPS_SRC 1:0
`define PMD_OPS_PAT 3:2
`define PMD_OPS_DST 5:4
`define PMD_OPS_SRCFIX 6
`define PMD_OPS_PATFIX 7
`define PMD_OPS_PATSRC 8
`define PMD_OPS_MASK 10:9
`define PMD_OPS_CMP 12:11
`define PMD_OPS_FGFN 20:16
`define PMD_OPS_BGFN 28:24
`define PMD_MASK_OFF 2'h0
`define PMD_MASK_BOUND 2'h1
`define PMD_MASK_EN 2'h2
`define PMD_CMP_OFF 2'h0
`define PMD_CMP_NE 2'h1
`define PMD_CMP_EQ 2'h2
`define PMD_VID_HI 31
`define PMD_VID_LO 22
`define PMD_RST_WORD 32'h0000_0000
`endif

/* File: hdl/pmd_pkg.sv */
package pmd_pkg;
  typedef struct packed {
    logic [31:0] base;
    logic [11:0] wid;
    logic [11:0] hgt;
    logic [1:0] depth;
    logic msbFirst;
  } pmd_map_type;

  typedef struct packed {
    logic [31:0] addr;
    logic [4:0] shift;
  } pmd_loc_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic video;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pmd_mem_req_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ISSUE = 4'h2,
    ST_WAIT = 4'h4,
    ST_STEP = 4'h8
  } pmd_state_type;

  typedef enum logic [4:0] {
    PH_SRC = 5'h01,
    PH_PAT = 5'h02,
    PH_MSK = 5'h04,
    PH_DRD = 5'h08,
    PH_DWR = 5'h10
  } pmd_phase_type;
endpackage : pmd_pkg

/* File: hdl/pmd_engine.sv */
`include "pmd_defs.svh"

module pmd_engine (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output pmd_pkg::pmd_mem_req_type memReq,
  input wire logic memAck,
  input wire logic [31:0] memRdata,
  output logic opDoneIrq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [7:0] pelMask(input logic [1:0] depth);
    logic [7:0] r;
    r = 8'h01;
    unique case (depth)
      2'h0: r = 8'h01;
      2'h1: r = 8'h03;
      2'h2: r = 8'h0f;
      2'h3: r = 8'hff;
    endcase
    return r; // [R4]
  endfunction : pelMask

  function automatic pmd_pkg::pmd_loc_type pelLoc(
    input pmd_pkg::pmd_map_type m,
    input logic [11:0] x,
    input logic [11:0] y
  );
    logic [23:0] idx;
    logic [26:0] bitOff;
    logic [4:0] pos;
    pmd_pkg::pmd_loc_type r;
    idx = 24'(y * ({1'b0, m.wid} + 13'h0001)) + {12'h000, x};
    bitOff = {3'h0, idx} << m.depth; // [R4]
    pos = bitOff[4:0];
    r.addr = m.base + {8'h00, bitOff[26:5], 2'h0};
    // Packing order per map, so order mismatch converts itself
    r.shift = m.msbFirst ?
      5'(6'h20 - (6'h01 << m.depth) - {1'b0, pos}) : pos; // [R5]
    return r;
  endfunction : pelLoc

  function automatic logic [7:0] getPel(input logic [31:0] w,
    input logic [4:0] sh, input logic [1:0] depth);
    return 8'(w >> sh) & pelMask(depth);
  endfunction : getPel

  function automatic logic [31:0] putPel(input logic [31:0] w,
    input logic [4:0] sh, input logic [1:0] depth, input logic [7:0] v);
    logic [31:0] msk;
    msk = {24'h000000, pelMask(depth)} << sh;
    return (w & ~msk) | ({24'h000000, v & pelMask(depth)} << sh);
  endfunction : putPel

  function automatic logic [7:0] mixPel(input logic [4:0] fn,
    input logic [7:0] s, input logic [7:0] d, input logic [1:0] depth);
    logic [7:0] r;
    r = 8'h00;
    if (fn[4]) begin
      unique case (fn[1:0])
        2'h0: r = d + s;
        2'h1: r = d - s;
        2'h2: r = (s > d) ? s : d;
        2'h3: r = (s < d) ? s : d;
      endcase
    end else begin
      for (int i = 0; i < 8; i++) begin
        r[i] = fn[{s[i], d[i]}];
      end
    end
    return r & pelMask(depth); // [R6]
  endfunction : mixPel

  function automatic logic [11:0] wrapInc(input logic [11:0] v,
    input logic [11:0] lim);
    return (v >= lim) ? 12'h000 : v + 12'h001; // [R12]
  endfunction : wrapInc

  function automatic logic inMap(input logic [15:0] x, input logic [15:0] y,
    input pmd_pkg::pmd_map_type m);
    return (x[15:12] == 4'h0) && (x[11:0] <= m.wid) &&
      (y[15:12] == 4'h0) && (y[11:0] <= m.hgt); // [R24]
  endfunction : inMap

  function automatic logic mapped(input logic [7:0] a);
    return (a <= `PMD_OFF_MOFF) ||
      (a[7:6] == `PMD_MAP_REGION && a[3:2] != 2'h3);
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////////
  // Register group

  logic [31:0] ops_ff, nxt_ops;
  logic [31:0] fg_ff, nxt_fg;
  logic [31:0] bg_ff, nxt_bg;
  logic [31:0] cmp_ff, nxt_cmp;
  logic [31:0] vbase_ff, nxt_vbase;
  logic [31:0] dim_ff, nxt_dim;
  logic [31:0] srcXY_ff, nxt_srcXY;
  logic [31:0] patXY_ff, nxt_patXY;
  logic [31:0] dstXY_ff, nxt_dstXY;
  logic [31:0] moff_ff, nxt_moff;
  pmd_pkg::pmd_map_type maps_ff [4];
  pmd_pkg::pmd_map_type nxt_maps [4];
  logic suspend_ff, nxt_suspend;
  logic termReq_ff, nxt_termReq;
  logic irqEn_ff, nxt_irqEn;
  logic irqSt_ff, nxt_irqSt;
  logic [31:0] prdata_ff, nxt_prdata;

  pmd_pkg::pmd_state_type state_ff, nxt_state;
  logic wrAcc, startPulse, engineDone, busy;

  assign wrAcc = psel && penable && pwrite;
  assign busy = (state_ff != pmd_pkg::ST_IDLE); // [R25]
  assign startPulse = wrAcc && paddr == `PMD_OFF_OPS && !busy; // [R1]
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign prdata = prdata_ff;
  assign opDoneIrq = irqSt_ff && irqEn_ff; // [R3]

  always_comb begin
    logic [1:0] mi;
    mi = paddr[5:4];
    nxt_ops = ops_ff;
    nxt_fg = fg_ff;
    nxt_bg = bg_ff;
    nxt_cmp = cmp_ff;
    nxt_vbase = vbase_ff;
    nxt_dim = dim_ff;
    nxt_srcXY = srcXY_ff;
    nxt_patXY = patXY_ff;
    nxt_dstXY = dstXY_ff;
    nxt_moff = moff_ff;
    nxt_maps = maps_ff;
    nxt_suspend = suspend_ff;
    nxt_termReq = termReq_ff && busy;
    nxt_irqEn = irqEn_ff;
    nxt_irqSt = irqSt_ff;
    nxt_prdata = prdata_ff;
    if (wrAcc) begin
      unique case (paddr)
        `PMD_OFF_OPS: if (!busy) nxt_ops = pwdata;
        `PMD_OFF_CTRL: begin
          nxt_suspend = pwdata[0]; // [R22]
          nxt_termReq = pwdata[1] && busy; // [R22]
        end
        `PMD_OFF_IRQEN: nxt_irqEn = pwdata[0];
        `PMD_OFF_IRQST: if (pwdata[0]) nxt_irqSt = 1'b0;
        `PMD_OFF_FG: nxt_fg = pwdata; // [R15]
        `PMD_OFF_BG: nxt_bg = pwdata; // [R15]
        `PMD_OFF_CMP: nxt_cmp = pwdata;
        `PMD_OFF_VBASE: nxt_vbase = pwdata;
        `PMD_OFF_DIM: nxt_dim = pwdata;
        `PMD_OFF_SRCXY: nxt_srcXY = pwdata;
        `PMD_OFF_PATXY: nxt_patXY = pwdata;
        `PMD_OFF_DSTXY: nxt_dstXY = pwdata;
        `PMD_OFF_MOFF: nxt_moff = pwdata;
        default: begin
          if (paddr[7:6] == `PMD_MAP_REGION) begin
            unique case (paddr[3:2])
              `PMD_MAP_BASE: nxt_maps[mi].base = pwdata;
              `PMD_MAP_SIZE: begin
                nxt_maps[mi].wid = pwdata[11:0]; // [R18]
                nxt_maps[mi].hgt = pwdata[27:16]; // [R18]
              end
              `PMD_MAP_FMT: begin
                // Mask map depth stays one bit
                nxt_maps[mi].depth = (mi == `PMD_MASK_MAP) ?
                  2'h0 : pwdata[1:0]; // [R21]
                nxt_maps[mi].msbFirst = pwdata[2]; // [R5]
              end
              default: ;
            endcase
          end
        end
      endcase
    end
    if (engineDone) begin
      nxt_irqSt = 1'b1; // [R3]
    end
    if (psel && !penable && !pwrite) begin
      nxt_prdata = 32'h00000000;
      unique case (paddr)
        `PMD_OFF_OPS: nxt_prdata = ops_ff;
        `PMD_OFF_STATUS: nxt_prdata = {30'h0, busy && suspend_ff, busy};
        `PMD_OFF_CTRL: nxt_prdata = {30'h0, termReq_ff, suspend_ff};
        `PMD_OFF_IRQEN: nxt_prdata = {31'h0, irqEn_ff};
        `PMD_OFF_IRQST: nxt_prdata = {31'h0, irqSt_ff};
        `PMD_OFF_FG: nxt_prdata = fg_ff;
        `PMD_OFF_BG: nxt_prdata = bg_ff;
        `PMD_OFF_CMP: nxt_prdata = cmp_ff;
        `PMD_OFF_VBASE: nxt_prdata = vbase_ff;
        `PMD_OFF_DIM: nxt_prdata = dim_ff;
        `PMD_OFF_SRCXY: nxt_prdata = srcXY_ff;
        `PMD_OFF_PATXY: nxt_prdata = patXY_ff;
        `PMD_OFF_DSTXY: nxt_prdata = dstXY_ff;
        `PMD_OFF_MOFF: nxt_prdata = moff_ff;
        default: begin
          if (paddr[7:6] == `PMD_MAP_REGION) begin
            unique case (paddr[3:2])
              `PMD_MAP_BASE: nxt_prdata = maps_ff[mi].base;
              `PMD_MAP_SIZE: nxt_prdata = {4'h0, maps_ff[mi].hgt,
                4'h0, maps_ff[mi].wid};
              `PMD_MAP_FMT: nxt_prdata = {29'h0, maps_ff[mi].msbFirst,
                maps_ff[mi].depth};
              default: ;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ops_ff <= `PMD_RST_WORD;
      fg_ff <= `PMD_RST_WORD;
      bg_ff <= `PMD_RST_WORD;
      cmp_ff <= `PMD_RST_WORD;
      vbase_ff <= `PMD_RST_WORD;
      dim_ff <= `PMD_RST_WORD;
      srcXY_ff <= `PMD_RST_WORD;
      patXY_ff <= `PMD_RST_WORD;
      dstXY_ff <= `PMD_RST_WORD;
      moff_ff <= `PMD_RST_WORD;
      for (int m = 0; m < 4; m++) begin
        maps_ff[m] <= '0;
      end
      suspend_ff <= 1'b0;
      termReq_ff <= 1'b0;
      irqEn_ff <= 1'b0;
      irqSt_ff <= 1'b0;
      prdata_ff <= `PMD_RST_WORD;
    end else begin
      ops_ff <= nxt_ops;
      fg_ff <= nxt_fg;
      bg_ff <= nxt_bg;
      cmp_ff <= nxt_cmp;
      vbase_ff <= nxt_vbase;
      dim_ff <= nxt_dim;
      srcXY_ff <= nxt_srcXY;
      patXY_ff <= nxt_patXY;
      dstXY_ff <= nxt_dstXY;
      moff_ff <= nxt_moff;
      maps_ff <= nxt_maps;
      suspend_ff <= nxt_suspend;
      termReq_ff <= nxt_termReq;
      irqEn_ff <= nxt_irqEn;
      irqSt_ff <= nxt_irqSt;
      prdata_ff <= nxt_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drawing engine

  pmd_pkg::pmd_phase_type phase_ff, nxt_phase;
  logic [11:0] srcX_ff, nxt_srcX, srcY_ff, nxt_srcY;
  logic [11:0] patX_ff, nxt_patX, patY_ff, nxt_patY;
  logic [15:0] dstX_ff, nxt_dstX, dstY_ff, nxt_dstY;
  logic [11:0] cntX_ff, nxt_cntX, cntY_ff, nxt_cntY;
  logic [7:0] srcPel_ff, nxt_srcPel;
  logic patBit_ff, nxt_patBit;
  logic mskBit_ff, nxt_mskBit;
  logic [31:0] dstWord_ff, nxt_dstWord;
  pmd_pkg::pmd_mem_req_type memReq_ff, nxt_memReq;

  pmd_pkg::pmd_map_type srcMap, patMap, dstMap, mskMap;
  pmd_pkg::pmd_loc_type srcLoc, patLoc, dstLoc, mskLoc;
  logic [15:0] mx, my;
  logic [1:0] maskMode;
  logic patVal, areaOk, mskPass, cmpOk, writeOk;
  logic [7:0] srcVal, dstPel, mixOut;

  assign memReq = memReq_ff;
  assign srcMap = maps_ff[ops_ff[`PMD_OPS_SRC]]; // [R19]
  assign patMap = maps_ff[ops_ff[`PMD_OPS_PAT]]; // [R19]
  assign dstMap = maps_ff[ops_ff[`PMD_OPS_DST]]; // [R19]
  assign mskMap = maps_ff[`PMD_MASK_MAP];
  assign maskMode = ops_ff[`PMD_OPS_MASK];
  assign mx = dstX_ff - moff_ff[15:0]; // [R14]
  assign my = dstY_ff - moff_ff[31:16]; // [R14]
  assign srcLoc = pelLoc(srcMap, srcX_ff, srcY_ff);
  assign patLoc = pelLoc(patMap, patX_ff, patY_ff);
  assign dstLoc = pelLoc(dstMap, dstX_ff[11:0], dstY_ff[11:0]);
  assign mskLoc = pelLoc(mskMap, mx[11:0], my[11:0]);
  // Pattern 1 when fixed; from source nonzero when derived
  assign patVal = ops_ff[`PMD_OPS_PATFIX] ? 1'b1 : // [R15]
    ops_ff[`PMD_OPS_PATSRC] ? (srcPel_ff != 8'h00) : patBit_ff; // [R9]
  assign srcVal = ops_ff[`PMD_OPS_SRCFIX] ?
    (patVal ? fg_ff[7:0] : bg_ff[7:0]) : srcPel_ff; // [R15]
  assign dstPel = getPel(dstWord_ff, dstLoc.shift, dstMap.depth);
  assign mixOut = mixPel(patVal ? ops_ff[`PMD_OPS_FGFN] :
    ops_ff[`PMD_OPS_BGFN], srcVal, dstPel, dstMap.depth); // [R7]
  assign areaOk = inMap(dstX_ff, dstY_ff, dstMap) && // [R13]
    (maskMode == `PMD_MASK_OFF || inMap(mx, my, mskMap)); // [R14]
  assign mskPass = maskMode != `PMD_MASK_EN || mskBit_ff; // [R8] [R23]
  always_comb begin
    cmpOk = 1'b1;
    unique case (ops_ff[`PMD_OPS_CMP])
      `PMD_CMP_NE: cmpOk = dstPel != (cmp_ff[7:0] & pelMask(dstMap.depth));
      `PMD_CMP_EQ: cmpOk = dstPel == (cmp_ff[7:0] & pelMask(dstMap.depth));
      default: cmpOk = 1'b1;
    endcase // [R10]
  end
  assign writeOk = areaOk && mskPass && cmpOk;
  assign engineDone = state_ff == pmd_pkg::ST_STEP &&
    cntX_ff == dim_ff[11:0] && cntY_ff == dim_ff[27:16]; // [R2]

  always_comb begin
    logic need;
    pmd_pkg::pmd_loc_type loc;
    pmd_pkg::pmd_phase_type after;
    need = 1'b0;
    loc = dstLoc;
    after = pmd_pkg::PH_SRC;
    nxt_state = state_ff;
    nxt_phase = phase_ff;
    nxt_srcX = srcX_ff;
    nxt_srcY = srcY_ff;
    nxt_patX = patX_ff;
    nxt_patY = patY_ff;
    nxt_dstX = dstX_ff;
    nxt_dstY = dstY_ff;
    nxt_cntX = cntX_ff;
    nxt_cntY = cntY_ff;
    nxt_srcPel = srcPel_ff;
    nxt_patBit = patBit_ff;
    nxt_mskBit = mskBit_ff;
    nxt_dstWord = dstWord_ff;
    nxt_memReq = memReq_ff;
    unique case (phase_ff)
      pmd_pkg::PH_SRC: begin
        need = !ops_ff[`PMD_OPS_SRCFIX]; // [R16]
        loc = srcLoc;
        after = pmd_pkg::PH_PAT;
      end
      pmd_pkg::PH_PAT: begin
        need = !ops_ff[`PMD_OPS_PATFIX] && !ops_ff[`PMD_OPS_PATSRC];
        loc = patLoc;
        after = pmd_pkg::PH_MSK;
      end
      pmd_pkg::PH_MSK: begin
        need = maskMode == `PMD_MASK_EN && areaOk;
        loc = mskLoc;
        after = pmd_pkg::PH_DRD;
      end
      pmd_pkg::PH_DRD: begin
        need = areaOk && mskPass;
        after = pmd_pkg::PH_DWR;
      end
      pmd_pkg::PH_DWR: begin
        need = writeOk; // [R13]
        after = pmd_pkg::PH_SRC;
      end
    endcase
    unique case (state_ff)
      pmd_pkg::ST_IDLE: begin
        if (startPulse) begin
          nxt_state = pmd_pkg::ST_ISSUE; // [R1]
          nxt_phase = pmd_pkg::PH_SRC;
          nxt_srcX = srcXY_ff[11:0];
          nxt_srcY = srcXY_ff[27:16];
          nxt_patX = patXY_ff[11:0];
          nxt_patY = patXY_ff[27:16];
          nxt_dstX = dstXY_ff[15:0];
          nxt_dstY = dstXY_ff[31:16];
          nxt_cntX = 12'h000;
          nxt_cntY = 12'h000;
        end
      end
      pmd_pkg::ST_ISSUE: begin
        if (phase_ff == pmd_pkg::PH_SRC && termReq_ff) begin
          nxt_state = pmd_pkg::ST_IDLE; // [R22]
        end else if (phase_ff == pmd_pkg::PH_SRC && suspend_ff) begin
          nxt_state = pmd_pkg::ST_ISSUE; // [R22]
        end else if (need) begin
          nxt_memReq.valid = 1'b1;
          nxt_memReq.write = phase_ff == pmd_pkg::PH_DWR;
          nxt_memReq.addr = loc.addr;
          nxt_memReq.video = loc.addr[`PMD_VID_HI:`PMD_VID_LO] ==
            vbase_ff[`PMD_VID_HI:`PMD_VID_LO]; // [R17]
          nxt_memReq.wdata = putPel(dstWord_ff, dstLoc.shift,
            dstMap.depth, mixOut); // [R6]
          nxt_state = pmd_pkg::ST_WAIT;
        end else begin
          nxt_phase = after;
          if (phase_ff == pmd_pkg::PH_DWR) begin
            nxt_state = pmd_pkg::ST_STEP;
          end
        end
      end
      pmd_pkg::ST_WAIT: begin
        if (memAck) begin
          nxt_memReq.valid = 1'b0;
          nxt_phase = after;
          nxt_state = (phase_ff == pmd_pkg::PH_DWR) ?
            pmd_pkg::ST_STEP : pmd_pkg::ST_ISSUE;
          unique case (phase_ff)
            pmd_pkg::PH_SRC: nxt_srcPel =
              getPel(memRdata, srcLoc.shift, srcMap.depth);
            pmd_pkg::PH_PAT: nxt_patBit = memRdata[patLoc.shift];
            pmd_pkg::PH_MSK: nxt_mskBit = memRdata[mskLoc.shift]; // [R21]
            pmd_pkg::PH_DRD: nxt_dstWord = memRdata;
            pmd_pkg::PH_DWR: ;
          endcase
        end
      end
      pmd_pkg::ST_STEP: begin
        nxt_state = pmd_pkg::ST_ISSUE;
        if (engineDone) begin
          nxt_state = pmd_pkg::ST_IDLE; // [R2] [R11]
        end else if (cntX_ff == dim_ff[11:0]) begin
          nxt_cntX = 12'h000;
          nxt_cntY = cntY_ff + 12'h001;
          nxt_srcX = srcXY_ff[11:0];
          nxt_patX = patXY_ff[11:0];
          nxt_dstX = dstXY_ff[15:0];
          nxt_srcY = wrapInc(srcY_ff, srcMap.hgt); // [R12]
          nxt_patY = wrapInc(patY_ff, patMap.hgt); // [R12]
          nxt_dstY = dstY_ff + 16'h0001; // [R11]
        end else begin
          nxt_cntX = cntX_ff + 12'h001;
          nxt_srcX = wrapInc(srcX_ff, srcMap.wid); // [R12]
          nxt_patX = wrapInc(patX_ff, patMap.wid); // [R12]
          nxt_dstX = dstX_ff + 16'h0001; // [R11]
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_ff <= pmd_pkg::ST_IDLE;
      phase_ff <= pmd_pkg::PH_SRC;
      srcX_ff <= 12'h000;
      srcY_ff <= 12'h000;
      patX_ff <= 12'h000;
      patY_ff <= 12'h000;
      dstX_ff <= 16'h0000;
      dstY_ff <= 16'h0000;
      cntX_ff <= 12'h000;
      cntY_ff <= 12'h000;
      srcPel_ff <= 8'h00;
      patBit_ff <= 1'b0;
      mskBit_ff <= 1'b0;
      dstWord_ff <= `PMD_RST_WORD;
      memReq_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
      srcX_ff <= nxt_srcX;
      srcY_ff <= nxt_srcY;
      patX_ff <= nxt_patX;
      patY_ff <= nxt_patY;
      dstX_ff <= nxt_dstX;
      dstY_ff <= nxt_dstY;
      cntX_ff <= nxt_cntX;
      cntY_ff <= nxt_cntY;
      srcPel_ff <= nxt_srcPel;
      patBit_ff <= nxt_patBit;
      mskBit_ff <= nxt_mskBit;
      dstWord_ff <= nxt_dstWord;
      memReq_ff <= nxt_memReq;
    end
  end

endmodule : pmd_engine

/* File: dv/pmd_engine_chk.sv */
`include "pmd_defs.svh"
module pmd_engine_chk (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire pmd_pkg::pmd_mem_req_type memReq,
  input wire logic memAck,
  input wire logic [31:0] memRdata,
  input wire logic opDoneIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr;
  logic irqEn_ff;
  logic nxt_irqEn;
  logic [9:0] vid_ff;
  logic [9:0] nxt_vid;
  assign wr = psel && penable && pwrite;
  // Shadow of enable and video base
  always_comb begin
    nxt_irqEn = irqEn_ff;
    nxt_vid = vid_ff;
    if (wr && paddr == `PMD_OFF_IRQEN) nxt_irqEn = pwdata[0];
    if (wr && paddr == `PMD_OFF_VBASE) nxt_vid = pwdata[31:22];
  end
  always_ff @(posedge sys_clk) begin
    irqEn_ff <= resetn ? nxt_irqEn : 1'b0;
    vid_ff <= resetn ? nxt_vid : 10'h0;
  end
  ////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  AST_ERR_HI: assert property (psel && penable && paddr >= 8'h80
    |-> pslverr)
    else $error("unmapped access not refused");
  AST_ERR_LO: assert property (psel && penable && paddr <= 8'h34
    |-> !pslverr)
    else $error("mapped access refused");
  AST_START: assert property (wr && paddr == `PMD_OFF_OPS &&
    !memReq.valid |-> ##[1:3] memReq.valid)
    else $error("start write gave no fetch");
  AST_HOLD: assert property (memReq.valid && !memAck
    |=> $stable(memReq))
    else $error("memory request changed before ack");
  AST_DROP: assert property (memReq.valid && memAck |=> !memReq.valid)
    else $error("request stayed after ack");
  AST_VIDEO: assert property (memReq.valid |->
    memReq.video == (memReq.addr[31:22] == vid_ff))
    else $error("video window decode wrong");
  AST_GATE: assert property (!irqEn_ff |-> !opDoneIrq)
    else $error("interrupt while disabled");
  AST_CLR: assert property (wr && paddr == `PMD_OFF_IRQST &&
    pwdata[0] && !memReq.valid |=> !opDoneIrq)
    else $error("interrupt not cleared");
endmodule : pmd_engine_chk
bind pmd_engine pmd_engine_chk chk_u (.sys_clk, .resetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .memReq, .memAck,
  .memRdata, .opDoneIrq);

/* File: dv/pmd_mem_model.sv */
module pmd_mem_model (
  input wire logic sys_clk,
  input wire pmd_pkg::pmd_mem_req_type memReq,
  input wire logic [1:0] ackDelay,
  output logic memAck,
  output logic [31:0] memRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:15];
  logic [31:0] last = 32'h0;
  int cnt = 0;
  // Idle read bus shows the inverse of the last word
  always @(posedge sys_clk) begin
    memAck <= 1'b0;
    memRdata <= ~last;
    if (memReq.valid && !memAck && cnt < ackDelay) cnt <= cnt + 1;
    else if (memReq.valid && !memAck) begin
      cnt <= 0;
      memAck <= 1'b1;
      if (memReq.write) mem[memReq.addr[5:2]] <= memReq.wdata;
      else begin
        memRdata <= mem[memReq.addr[5:2]];
        last <= mem[memReq.addr[5:2]];
      end
    end
  end
endmodule : pmd_mem_model

/* File: dv/test_pel_map_drawing_engine.sv */
`include "pmd_defs.svh"
module test_pel_map_drawing_engine;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk;
  logic resetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  pmd_pkg::pmd_mem_req_type memReq;
  logic memAck;
  logic [31:0] memRdata;
  logic opDoneIrq;
  logic [1:0] ackDelay;
  logic [31:0] rnd = 32'hd1aa1d09;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int fns [6] = '{5'h0c, 5'h06, 5'h10, 5'h11, 5'h12, 5'h13};
  logic [7:0] ra [3] = '{`PMD_OFF_STATUS, `PMD_OFF_IRQST, 8'h80};
  logic [7:0] sa [13] = '{8'h40, 8'h44, 8'h48, 8'h50, 8'h54, 8'h58,
    8'h70, 8'h74, 8'h78, 8'h24, 8'h2c, 8'h30, 8'h34};
  logic [31:0] sv [13] = '{32'h0, 32'h10003, 32'h3, 32'h20, 32'h1f, 32'h4,
    32'h30, 32'h1f, 32'h3, 32'h2, 32'h1f, 32'h10002, 32'h10003};
  pmd_engine dut_u (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .memReq, .memAck, .memRdata,
    .opDoneIrq);
  pmd_mem_model mem_u (.sys_clk, .memReq, .ackDelay, .memAck, .memRdata);
  always #20 sys_clk = ~sys_clk;
  ////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic int mix(input int f, input int s, input int d);
    int r;
    r = 0;
    if (f[4]) begin
      case (f & 3)
        0: r = d + s;
        1: r = d - s;
        2: r = (d > s) ? d : s;
        default: r = (d < s) ? d : s;
      endcase
    end else begin
      for (int i = 0; i < 8; i++) r |= f[{s[i], d[i]}] << i;
    end
    return r & 255;
  endfunction : mix
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic end_sim;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic wait_idle(output logic [31:0] r);
    repeat (300) begin
      apb(1'b0, `PMD_OFF_STATUS, 32'h0, r);
      if (r[0] === 1'b0) break;
    end
  endtask : wait_idle
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      end_sim();
    end
  end
  ////////////////////////////////
  initial begin
    logic [31:0] r, old, pat, msk, fg, bg, ex;
    int x, p, s, f, d, mm, cm, cmpv;
    sys_clk = 1'b0;
    resetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ackDelay = 2'h0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0, r);
      chk(r, 32'h0);
    end
    foreach (sa[i]) apb(1'b1, sa[i], sv[i], r);
    for (int k = 0; k < 4; k++) begin
      old = lfsr(rnd);
      pat = lfsr(old);
      msk = lfsr(pat);
      rnd = lfsr(msk);
      fg = rnd[7:0];
      bg = rnd[31:24];
      mm = k[1] ? k - 1 : 0;
      cm = (k == 1) ? 1 : (k == 3) ? 2 : 0;
      cmpv = k[1] ? old[31:24] : old[23:16];
      mem_u.mem[0] = ~old;
      mem_u.mem[1] = old;
      mem_u.mem[2] = ~old;
      mem_u.mem[8] = pat;
      mem_u.mem[12] = msk;
      ackDelay <= rnd[9:8];
      apb(1'b1, `PMD_OFF_FG, fg, r);
      apb(1'b1, `PMD_OFF_BG, bg, r);
      apb(1'b1, `PMD_OFF_CMP, cmpv, r);
      apb(1'b1, `PMD_OFF_IRQEN, k & 1, r);
      apb(1'b1, `PMD_OFF_VBASE, k[0] ? 32'h0 : 32'h00c00000, r);
      apb(1'b1, `PMD_OFF_OPS, (k == 1 ? 32'h104 : 32'h44) | mm << 9
        | cm << 11 | fns[k] << 16 | fns[k + 2] << 24, r);
      apb(1'b0, `PMD_OFF_STATUS, 32'h0, r);
      chk(r[0], 1'b1);
      wait_idle(r);
      chk(r[0], 1'b0);
      ex = old;
      for (int i = 0; i < 2; i++) begin
        x = 2 + i;
        s = old[i * 8 +: 8] ^ 8'hff;
        p = (k == 1) ? (s != 0) : pat[31 - ((31 + i) % 32)];
        if (k != 1) s = p ? fg : bg;
        f = p ? fns[k] : fns[k + 2];
        d = old[x * 8 +: 8];
        if (!(mm != 0 && (x < 3 || (mm == 2 && !msk[x - 3]))) &&
          !(cm == 1 && d == cmpv) && !(cm == 2 && d != cmpv))
          ex[x * 8 +: 8] = mix(f, s, d);
      end
      chk(mem_u.mem[0], ~old);
      chk(mem_u.mem[1], ex);
      chk(mem_u.mem[2], ~old);
      chk(opDoneIrq, k & 1);
      apb(1'b0, `PMD_OFF_IRQST, 32'h0, r);
      chk(r[0], 1'b1);
      apb(1'b1, `PMD_OFF_IRQST, 32'h1, r);
      chk(opDoneIrq, 1'b0);
    end
    // Park a slow run between pixels, then abort it
    ackDelay <= 2'h3;
    apb(1'b1, `PMD_OFF_OPS, 32'h44, r);
    apb(1'b1, `PMD_OFF_CTRL, 32'h1, r);
    repeat (200) @(posedge sys_clk);
    apb(1'b0, `PMD_OFF_STATUS, 32'h0, r);
    chk(r, 32'h3);
    apb(1'b1, `PMD_OFF_CTRL, 32'h2, r);
    wait_idle(r);
    chk(r[0], 1'b0);
    apb(1'b0, `PMD_OFF_IRQST, 32'h0, r);
    chk(r[0], 1'b0);
    end_sim();
  end
endmodule : test_pel_map_drawing_engine
